// *** verilog/hbm_consts.vh ***
/*
 * Shared constants for the H-bridge motor control logic: bridge states,
 * output drive codes and timing figures.
 * Assumes a 10 MHz reference clock; counts derive from the rate below.
 */
`ifndef HBM_CONSTS_VH
`define HBM_CONSTS_VH

// ==========================================================================
// Clock rate
// ==========================================================================
`define HBM_CLK_HZ          10000000

// ==========================================================================
// Timing figures in their own units, then cycle counts
// ==========================================================================
`define HBM_BRAKE_HOLD_US   1000
`define HBM_OFF_TIME_US     11
`define HBM_BLANK_NS        200
`define HBM_WAKE_US         500
`define HBM_OC_RETRY_US     4000
`define HBM_BRAKE_HOLD_CYC  ((`HBM_BRAKE_HOLD_US * (`HBM_CLK_HZ / 1000000)))
`define HBM_OFF_TIME_CYC    ((`HBM_OFF_TIME_US * (`HBM_CLK_HZ / 1000000)))
`define HBM_BLANK_CYC       ((`HBM_BLANK_NS * (`HBM_CLK_HZ / 1000000) + 999) / 1000)
`define HBM_WAKE_CYC        ((`HBM_WAKE_US * (`HBM_CLK_HZ / 1000000)))
`define HBM_OC_RETRY_CYC    ((`HBM_OC_RETRY_US * (`HBM_CLK_HZ / 1000000)))

// ==========================================================================
// Half-bridge output drive codes {drive_en, level}
// ==========================================================================
`define HBM_OUT_Z           2'h0
`define HBM_OUT_LOW         2'h2
`define HBM_OUT_HIGH        2'h3

// ==========================================================================
// Commanded bridge function
// ==========================================================================
`define HBM_FN_COAST        2'h0
`define HBM_FN_REV          2'h1
`define HBM_FN_FWD          2'h2
`define HBM_FN_BRAKE        2'h3

`endif

// *** verilog/hbm_timer.v ***
/*
 * Down-counting interval timer: load starts a count of LENGTH cycles,
 * done pulses for one cycle when it runs out, busy is high meanwhile.
 * Assumes load is a one-cycle request; a new load restarts the count.
 */
`timescale 1ns/1ps

module hbm_timer #(
  parameter WIDTH  = 16,
  parameter LENGTH = 10
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             rstn,
  // Control
  input  wire             load,
  input  wire             abort,
  // Status
  output reg              busy,
  output reg              done
);

  reg [WIDTH-1:0] count_reg;

  // ========================================================================
  // Counter
  // ========================================================================
  // Abort wins so a shutdown never lets a stale interval expire
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= {WIDTH{1'b0}};
      busy      <= 1'b0;
      done      <= 1'b0;
    end else if (abort) begin
      count_reg <= {WIDTH{1'b0}};
      busy      <= 1'b0;
      done      <= 1'b0;
    end else if (load) begin
      count_reg <= LENGTH[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1};
      busy      <= 1'b1;
      done      <= 1'b0;
    end else if (busy && count_reg == {WIDTH{1'b0}}) begin
      busy      <= 1'b0;
      done      <= 1'b1;
    end else begin
      count_reg <= busy ? count_reg - {{(WIDTH-1){1'b0}}, 1'b1} : count_reg;
      done      <= 1'b0;
    end
  end

endmodule // hbm_timer

// *** verilog/hbm_input_decode.v ***
/*
 * Input decoder: maps the two-input or enable/direction pin pair onto a
 * bridge function and detects the held pattern that asks for low-quiescent
 * brake. Assumes pins are synchronous to ref_clk.
 */
`timescale 1ns/1ps
`include "hbm_consts.vh"

module hbm_input_decode #(
  parameter HOLD_WIDTH = 14,
  parameter HOLD_CYC   = `HBM_BRAKE_HOLD_CYC
) (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rstn,
  // Pins
  input  wire       variant_en_dir,
  input  wire       bridge_input_a,
  input  wire       bridge_input_b,
  input  wire       bridge_enable_in,
  input  wire       active,
  // Decoded
  output reg  [1:0] bridge_fn,
  output reg        lowq_brake
);

  reg [HOLD_WIDTH-1:0] hold_reg;
  reg [1:0]            fn_next;
  reg                  hold_pat;

  // ========================================================================
  // Truth tables
  // ========================================================================
  // Enable/direction variant never coasts: enable low is brake
  always @* begin
    hold_pat = 1'b0;
    if (variant_en_dir) begin
      if (!bridge_enable_in)
        fn_next = `HBM_FN_BRAKE;
      else if (bridge_input_a)
        fn_next = `HBM_FN_FWD;
      else
        fn_next = `HBM_FN_REV;
      hold_pat = !bridge_enable_in;
    end else begin
      case ({bridge_input_a, bridge_input_b})
        2'h0:    fn_next = `HBM_FN_COAST;
        2'h1:    fn_next = `HBM_FN_REV;
        2'h2:    fn_next = `HBM_FN_FWD;
        default: fn_next = `HBM_FN_BRAKE;
      endcase
      hold_pat = bridge_input_a && bridge_input_b;
    end
  end

  // ========================================================================
  // Held-pattern timer
  // ========================================================================
  // Saturates, so a long brake stays in low-quiescent mode
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hold_reg   <= {HOLD_WIDTH{1'b0}};
      lowq_brake <= 1'b0;
      bridge_fn  <= `HBM_FN_COAST;
    end else begin
      bridge_fn <= fn_next;
      if (!active || !hold_pat) begin
        hold_reg   <= {HOLD_WIDTH{1'b0}};
        lowq_brake <= 1'b0;
      end else if (hold_reg >= HOLD_CYC[HOLD_WIDTH-1:0] - {{(HOLD_WIDTH-1){1'b0}}, 1'b1}) begin
        lowq_brake <= 1'b1;
      end else begin
        hold_reg <= hold_reg + {{(HOLD_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // hbm_input_decode

// *** verilog/hbm_bridge_ctrl.v ***
/*
 * Top of the H-bridge motor control logic: input decode, constant-off-time
 * current regulation with blanking, sleep and wake, and fault sequencing
 * for overcurrent, overtemperature, undervoltage and overvoltage.
 * Assumes analog comparators arrive as clean levels synchronous to ref_clk
 * and that rstn also carries the undervoltage reset of the logic.
 */
`timescale 1ns/1ps
`include "hbm_consts.vh"

module hbm_bridge_ctrl #(
  parameter WAKE_CYC     = `HBM_WAKE_CYC,
  parameter OC_RETRY_CYC = `HBM_OC_RETRY_CYC,
  parameter HOLD_CYC     = `HBM_BRAKE_HOLD_CYC,
  parameter OFF_CYC      = `HBM_OFF_TIME_CYC,
  parameter BLANK_CYC    = `HBM_BLANK_CYC
) (
  // Clock and reset
  input  wire ref_clk,
  input  wire rstn,
  // Configuration
  input  wire variant_en_dir,
  input  wire overcurrent_select,
  // Host control pins
  input  wire bridge_input_a,
  input  wire bridge_input_b,
  input  wire bridge_enable_in,
  input  wire sleep_n_in,
  // Analog comparators
  input  wire current_set_grounded,
  input  wire trip_rise_cmp,
  input  wire trip_fall_cmp,
  input  wire overcurrent_lo_cmp,
  input  wire overcurrent_hi_cmp,
  input  wire short_to_supply_cmp,
  input  wire thermal_shutdown_level,
  input  wire supply_overvoltage_level,
  // Bridge gate drive
  output reg  hs1_on,
  output reg  ls1_on,
  output reg  hs2_on,
  output reg  ls2_on,
  // Support circuits
  output reg  charge_pump_en,
  output reg  sense_en,
  output reg  lowq_mode,
  // Fault pin
  output reg  fault_n_out,
  output reg  fault_oe
);

  // Regulation states
  localparam RG_DRIVE = 2'h0;
  localparam RG_DECAY = 2'h1;
  localparam RG_WAIT  = 2'h2;

  wire [1:0] bridge_fn;
  wire       lowq_brake;
  wire       wake_busy;
  wire       wake_done;
  wire       oc_busy;
  wire       oc_done;
  wire       off_busy;
  wire       off_done;
  wire       blank_busy;

  reg        awake_reg;
  reg        sleep_d_reg;
  reg        oc_latched_reg;
  reg [1:0]  rg_state_reg;
  reg [1:0]  rg_state_next;
  reg [1:0]  fn_prev_reg;
  reg        hs1_next;
  reg        ls1_next;
  reg        hs2_next;
  reg        ls2_next;
  reg        off_load;
  reg        blank_load;

  wire       oc_cmp;
  wire       oc_trip;
  wire       shutdown;
  wire       active;
  wire       reg_allowed;
  wire       driving;
  wire       ls_on;

  // ========================================================================
  // Input decode
  // ========================================================================
  hbm_input_decode #(
    .HOLD_WIDTH (14),
    .HOLD_CYC   (HOLD_CYC)
  ) u_decode (
    .ref_clk          (ref_clk),
    .rstn             (rstn),
    .variant_en_dir   (variant_en_dir),
    .bridge_input_a   (bridge_input_a),
    .bridge_input_b   (bridge_input_b),
    .bridge_enable_in (bridge_enable_in),
    .active           (active),
    .bridge_fn        (bridge_fn),
    .lowq_brake       (lowq_brake)
  );

  // ========================================================================
  // Sleep and wake
  // ========================================================================
  // start-up delay
  hbm_timer #(
    .WIDTH  (13),
    .LENGTH (WAKE_CYC)
  ) u_wake (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .load    (sleep_n_in && !sleep_d_reg),
    .abort   (!sleep_n_in),
    .busy    (wake_busy),
    .done    (wake_done)
  );

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sleep_d_reg <= 1'b0;
      awake_reg   <= 1'b0;
    end else begin
      sleep_d_reg <= sleep_n_in;
      if (!sleep_n_in)
        awake_reg <= 1'b0;
      else if (wake_done)
        awake_reg <= 1'b1;
    end
  end

  // ========================================================================
  // Overcurrent retry
  // ========================================================================
  // threshold select, floating is high
  assign oc_cmp  = overcurrent_select ? overcurrent_lo_cmp : overcurrent_hi_cmp;
  // Low-quiescent brake keeps only the short-to-supply check
  assign oc_trip = lowq_brake ? short_to_supply_cmp : oc_cmp;

  hbm_timer #(
    .WIDTH  (16),
    .LENGTH (OC_RETRY_CYC)
  ) u_oc (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .load    (active && oc_trip && !oc_latched_reg),
    .abort   (!awake_reg),
    .busy    (oc_busy),
    .done    (oc_done)
  );

  // Latch holds through the retry so a sticky short re-trips cleanly
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      oc_latched_reg <= 1'b0;
    else if (!awake_reg)
      oc_latched_reg <= 1'b0;
    else if (active && oc_trip)
      oc_latched_reg <= 1'b1;
    else if (oc_done)
      oc_latched_reg <= 1'b0;
  end

  // overvoltage level, hysteresis is in the comparator
  assign shutdown = oc_latched_reg || thermal_shutdown_level || supply_overvoltage_level;
  assign active   = awake_reg && !shutdown;

  // ========================================================================
  // Current regulation
  // ========================================================================
  // grounded node disables regulation
  assign reg_allowed = !current_set_grounded && !lowq_brake;
  assign driving     = (bridge_fn == `HBM_FN_FWD) || (bridge_fn == `HBM_FN_REV);

  hbm_timer #(
    .WIDTH  (8),
    .LENGTH (OFF_CYC)
  ) u_off (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .load    (off_load),
    .abort   (!active),
    .busy    (off_busy),
    .done    (off_done)
  );

  hbm_timer #(
    .WIDTH  (8),
    .LENGTH (BLANK_CYC)
  ) u_blank (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .load    (blank_load),
    .abort   (!active),
    .busy    (blank_busy),
    .done    ()
  );

  // Regulation state and bridge switch selection
  always @* begin
    rg_state_next = rg_state_reg;
    off_load      = 1'b0;
    blank_load    = 1'b0;
    hs1_next      = 1'b0;
    ls1_next      = 1'b0;
    hs2_next      = 1'b0;
    ls2_next      = 1'b0;
    if (!active || !driving || !reg_allowed) begin
      rg_state_next = RG_DRIVE;
    end else begin
      case (rg_state_reg)
        RG_DRIVE: begin
          // trip to slow decay, ignored while blanked
          if (trip_rise_cmp && !blank_busy) begin
            rg_state_next = RG_DECAY;
            off_load      = 1'b1;
          end
        end
        RG_DECAY: begin
          if (off_done && !trip_fall_cmp) begin
            rg_state_next = RG_DRIVE;
            blank_load    = 1'b1;
          end else if (off_done) begin
            rg_state_next = RG_WAIT;
          end
        end
        RG_WAIT: begin
          if (!trip_fall_cmp) begin
            rg_state_next = RG_DRIVE;
            blank_load    = 1'b1;
          end
        end
        default: rg_state_next = RG_DRIVE;
      endcase
    end
    // New drive direction counts as a turn-on
    if (active && driving && bridge_fn != fn_prev_reg)
      blank_load = 1'b1;
    if (active) begin
      case (bridge_fn)
        `HBM_FN_FWD: begin
          hs1_next = (rg_state_next == RG_DRIVE);
          ls2_next = 1'b1;
          ls1_next = (rg_state_next != RG_DRIVE);
        end
        `HBM_FN_REV: begin
          hs2_next = (rg_state_next == RG_DRIVE);
          ls1_next = 1'b1;
          ls2_next = (rg_state_next != RG_DRIVE);
        end
        `HBM_FN_BRAKE: begin
          ls1_next = 1'b1;
          ls2_next = 1'b1;
        end
        default: begin
          hs1_next = 1'b0;
        end
      endcase
    end
  end

  // sense while a low side conducts
  assign ls_on = ls1_next || ls2_next;

  // ========================================================================
  // Output registers
  // ========================================================================
  // lockout resets all state
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rg_state_reg   <= RG_DRIVE;
      fn_prev_reg    <= `HBM_FN_COAST;
      hs1_on         <= 1'b0;
      ls1_on         <= 1'b0;
      hs2_on         <= 1'b0;
      ls2_on         <= 1'b0;
      charge_pump_en <= 1'b0;
      sense_en       <= 1'b0;
      lowq_mode      <= 1'b0;
      fault_n_out    <= 1'b1;
      fault_oe       <= 1'b0;
    end else begin
      rg_state_reg   <= rg_state_next;
      fn_prev_reg    <= active ? bridge_fn : `HBM_FN_COAST;
      hs1_on         <= hs1_next;
      ls1_on         <= ls1_next;
      hs2_on         <= hs2_next;
      ls2_on         <= ls2_next;
      charge_pump_en <= sleep_n_in;
      sense_en       <= ls_on && !lowq_brake;
      lowq_mode      <= active && lowq_brake;
      // regulation never reaches the fault pin
      // open drain pulled low on protection faults
      fault_n_out    <= !(awake_reg && shutdown);
      fault_oe       <= awake_reg && shutdown;
    end
  end

endmodule // hbm_bridge_ctrl

// *** tb/hbm_ctrl_sva.sv ***
/* Port checker for hbm_bridge_ctrl: leg, sleep, fault and sense relations.
   Assumes comparator levels arrive synchronous to ref_clk. */
`timescale 1ns/1ps
// ==========================================================
// Port checker
module hbm_ctrl_sva (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  // Watched inputs
  input wire sleep_n_in,
  input wire overcurrent_select,
  input wire overcurrent_lo_cmp,
  input wire overcurrent_hi_cmp,
  input wire short_to_supply_cmp,
  input wire thermal_shutdown_level,
  input wire supply_overvoltage_level,
  // Watched outputs
  input wire hs1_on,
  input wire ls1_on,
  input wire hs2_on,
  input wire ls2_on,
  input wire charge_pump_en,
  input wire sense_en,
  input wire lowq_mode,
  input wire fault_n_out,
  input wire fault_oe
);
  // Bridge fully open, and no protection comparator active
  wire off = !(hs1_on | ls1_on | hs2_on | ls2_on);
  wire quiet = !(overcurrent_lo_cmp | overcurrent_hi_cmp | short_to_supply_cmp |
    thermal_shutdown_level | supply_overvoltage_level);
  wire oc_hit = overcurrent_select ? overcurrent_lo_cmp : overcurrent_hi_cmp;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_leg; !(hs1_on && ls1_on) && !(hs2_on && ls2_on); endproperty
  a_leg: assert property (p_leg) else $error("leg shorted");
  property p_sleep; !sleep_n_in [*2] |=> off && !charge_pump_en; endproperty
  a_sleep: assert property (p_sleep) else $error("drive in sleep");
  property p_wake; $rose(sleep_n_in) |-> off [*8]; endproperty
  a_wake: assert property (p_wake) else $error("early drive");
  property p_oc; (oc_hit && !lowq_mode) [*2] |=> off; endproperty
  a_oc: assert property (p_oc) else $error("drive in overcurrent");
  property p_ot; thermal_shutdown_level [*2] |=> off; endproperty
  a_ot: assert property (p_ot) else $error("drive when hot");
  property p_ov; supply_overvoltage_level [*2] |=> off; endproperty
  a_ov: assert property (p_ov) else $error("drive in overvoltage");
  property p_oe; fault_oe == !fault_n_out; endproperty
  a_oe: assert property (p_oe) else $error("fault enable mismatch");
  property p_quiet; quiet [*3] ##0 fault_n_out |=> fault_n_out; endproperty
  a_quiet: assert property (p_quiet) else $error("spurious fault");
  property p_lowq; lowq_mode |-> !sense_en; endproperty
  a_lowq: assert property (p_lowq) else $error("sense in brake mode");
  property p_sense; ((ls1_on | ls2_on) && !lowq_mode) [*2] |-> sense_en; endproperty
  a_sense: assert property (p_sense) else $error("sense missing");
endmodule // hbm_ctrl_sva

bind hbm_bridge_ctrl hbm_ctrl_sva hbm_ctrl_sva_i (.ref_clk, .rstn, .sleep_n_in,
  .overcurrent_select, .overcurrent_lo_cmp, .overcurrent_hi_cmp, .short_to_supply_cmp,
  .thermal_shutdown_level, .supply_overvoltage_level, .hs1_on, .ls1_on, .hs2_on,
  .ls2_on, .charge_pump_en, .sense_en, .lowq_mode, .fault_n_out, .fault_oe);

// *** tb/hbm_host_model.sv ***
/* Host model: drives the bridge pins with a 16-cycle PWM.
   Assumes commands change only at rising edges. */
`timescale 1ns/1ps
// ==========================================================
// PWM host
module hbm_host_model (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  // Commands
  input wire variant_en_dir,
  input wire [4:0] duty,
  input wire dir,
  input wire hold_brake,
  // Pins
  output reg bridge_input_a,
  output reg bridge_input_b,
  output reg bridge_enable_in
);
  reg [3:0] cnt_reg;
  wire on = {1'b0, cnt_reg} < duty;
  // Pins change only after an edge; duty 16 means full on
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 4'h0;
      bridge_input_a <= 1'b0;
      bridge_input_b <= 1'b0;
      bridge_enable_in <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      bridge_input_a <= variant_en_dir ? dir : (hold_brake | (dir & on));
      bridge_input_b <= hold_brake | (~dir & on);
      bridge_enable_in <= on & ~hold_brake;
    end
  end
endmodule // hbm_host_model

// *** tb/test_hbm_bridge_ctrl.sv ***
/* Self-checking bench for hbm_bridge_ctrl with the PWM host model.
   Assumes the shortened wake, retry and hold counts set below. */
`timescale 1ns/1ps
`define CHK(g, w) begin tests_run++; if ((g) !== (w)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h want=%h", $time, g, w); end end
// ==========================================================
// Bench top
module test_hbm_bridge_ctrl;
  localparam WK = 20, OCR = 50, HLD = 30, OFF = 110, BLK = 2;
  localparam [3:0] FWD = 4'h9, BRK = 4'h5;
  reg ref_clk, rstn, variant_en_dir, overcurrent_select, sleep_n_in, dir, hold_brake;
  reg current_set_grounded, trip_rise_cmp, trip_fall_cmp, overcurrent_lo_cmp;
  reg overcurrent_hi_cmp, thermal_shutdown_level, supply_overvoltage_level;
  reg short_to_supply_cmp;
  reg [4:0] duty;
  reg [3:0] p1, p2;
  reg [31:0] seed = 32'h661FE639;
  wire bridge_input_a, bridge_input_b, bridge_enable_in, hs1_on, ls1_on, hs2_on, ls2_on;
  wire charge_pump_en, sense_en, lowq_mode, fault_n_out, fault_oe;
  wire [3:0] gates = {hs1_on, ls1_on, hs2_on, ls2_on};
  integer bad_count = 0, tests_run = 0, i, n;

  hbm_host_model hbm_host_model_i (.ref_clk, .rstn, .variant_en_dir, .duty, .dir,
    .hold_brake, .bridge_input_a, .bridge_input_b, .bridge_enable_in);
  // Short counts keep the run brief
  hbm_bridge_ctrl #(.WAKE_CYC(WK), .OC_RETRY_CYC(OCR), .HOLD_CYC(HLD), .OFF_CYC(OFF),
    .BLANK_CYC(BLK)) hbm_bridge_ctrl_i (.ref_clk, .rstn, .variant_en_dir,
    .overcurrent_select, .bridge_input_a, .bridge_input_b, .bridge_enable_in,
    .sleep_n_in, .current_set_grounded, .trip_rise_cmp, .trip_fall_cmp,
    .overcurrent_lo_cmp, .overcurrent_hi_cmp, .short_to_supply_cmp,
    .thermal_shutdown_level, .supply_overvoltage_level, .hs1_on, .ls1_on, .hs2_on,
    .ls2_on, .charge_pump_en, .sense_en, .lowq_mode, .fault_n_out, .fault_oe);

  // Expected gates {hs1, ls1, hs2, ls2} from pins {variant, a, b, enable}
  function [3:0] exp_g(input [3:0] p);
    if (p[3]) exp_g = !p[0] ? BRK : (p[2] ? FWD : 4'h6);
    else exp_g = {p[2] & ~p[1], p[1], p[1] & ~p[2], p[2]};
  endfunction
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task tick(input integer k);
    repeat (k) @(posedge ref_clk);
  endtask
  // Bounded wait for gates and fault pin
  task wait_st(input [4:0] w, input integer lim);
    begin
      n = 0;
      @(negedge ref_clk);
      while ({gates, fault_n_out} !== w && n < lim) begin
        @(negedge ref_clk);
        n++;
      end
      `CHK({gates, fault_n_out}, w)
    end
  endtask
  // Sleep, then wake with full forward drive requested
  task wake;
    begin
      @(posedge ref_clk);
      sleep_n_in <= 1'b0;
      tick(3);
      @(negedge ref_clk);
      `CHK({gates, charge_pump_en}, 5'h00)
      @(posedge ref_clk);
      sleep_n_in <= 1'b1;
      tick(WK - 2);
      @(negedge ref_clk);
      `CHK(gates, 4'h0)
      wait_st({FWD, 1'b1}, 10);
      $display("wake test done");
    end
  endtask
  // Random PWM and trips with regulation off; gates follow pins two cycles late
  task track(input integer cyc);
    begin
      @(posedge ref_clk);
      current_set_grounded <= 1'b1;
      for (i = 0; i < cyc; i++) begin
        @(posedge ref_clk);
        if (i % 16 == 0) begin
          seed = lfsr(seed);
          duty <= {1'b0, seed[3:0]} + 5'h01;
          dir <= seed[4];
          trip_rise_cmp <= seed[5];
          trip_fall_cmp <= seed[6];
          overcurrent_hi_cmp <= seed[7];
        end
        @(negedge ref_clk);
        if (i >= 2) `CHK(gates, exp_g(p2))
        p2 = p1;
        p1 = {variant_en_dir, bridge_input_a, bridge_input_b, bridge_enable_in};
      end
      @(posedge ref_clk);
      {trip_rise_cmp, trip_fall_cmp, overcurrent_hi_cmp, current_set_grounded} <= 4'h0;
      duty <= 5'h10;
      dir <= 1'b1;
      $display("track test done");
    end
  endtask
  // Held brake pattern enters low-quiescent mode
  task lowq;
    begin
      @(posedge ref_clk);
      hold_brake <= 1'b1;
      tick(HLD + 6);
      @(negedge ref_clk);
      `CHK({gates, lowq_mode, sense_en}, {BRK, 2'b10})
      // Only the short-to-supply check survives low-quiescent brake
      @(posedge ref_clk);
      overcurrent_lo_cmp <= 1'b1;
      tick(3);
      @(negedge ref_clk);
      `CHK({gates, lowq_mode, fault_n_out}, {BRK, 2'b11})
      @(posedge ref_clk);
      overcurrent_lo_cmp <= 1'b0;
      short_to_supply_cmp <= 1'b1;
      tick(2);
      short_to_supply_cmp <= 1'b0;
      wait_st(5'h00, 4);
      wait_st({BRK, 1'b1}, OCR + 8);
      @(posedge ref_clk);
      hold_brake <= 1'b0;
      $display("brake mode test done");
    end
  endtask
  task complete_run;
    begin
      $display("compares %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask

  // Free-running 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Watchdog far beyond the expected run of under two thousand cycles
  initial begin
    #2000000;
    bad_count++;
    complete_run;
  end
  initial begin
    {rstn, variant_en_dir, sleep_n_in, current_set_grounded, trip_rise_cmp} = 5'h00;
    {trip_fall_cmp, overcurrent_lo_cmp, overcurrent_hi_cmp, hold_brake} = 4'h0;
    short_to_supply_cmp = 1'b0;
    {thermal_shutdown_level, supply_overvoltage_level} = 2'h0;
    overcurrent_select = 1'b1;
    duty = 5'h10;
    dir = 1'b1;
    tick(2);
    @(negedge ref_clk);
    `CHK({gates, charge_pump_en, fault_n_out, fault_oe}, 7'h02)
    @(posedge ref_clk);
    rstn <= 1'b1;
    wake;
    track(160);
    lowq;
    variant_en_dir <= 1'b1;
    wake;
    track(160);
    lowq;
    wake;
    // Trip, prolonged off while above 80 percent, then timed off and blanking
    @(posedge ref_clk);
    trip_rise_cmp <= 1'b1;
    trip_fall_cmp <= 1'b1;
    wait_st({BRK, 1'b1}, 6);
    @(posedge ref_clk);
    trip_rise_cmp <= 1'b0;
    tick(OFF + 10);
    @(negedge ref_clk);
    `CHK(gates, BRK)
    @(posedge ref_clk);
    trip_fall_cmp <= 1'b0;
    wait_st({FWD, 1'b1}, 6);
    @(posedge ref_clk);
    trip_rise_cmp <= 1'b1;
    wait_st({BRK, 1'b1}, 8);
    n = 0;
    while (gates === BRK && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK(n >= OFF - 2 && n <= OFF + 2, 1'b1)
    n = 0;
    while (gates === FWD && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK(n >= BLK && n <= BLK + 2, 1'b1)
    @(posedge ref_clk);
    trip_rise_cmp <= 1'b0;
    wait_st({FWD, 1'b1}, 130);
    $display("regulation test done");
    // Both threshold selections: the other comparator is ignored
    for (i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      overcurrent_select <= i[0];
      if (i) overcurrent_hi_cmp <= 1'b1;
      else overcurrent_lo_cmp <= 1'b1;
      tick(5);
      @(negedge ref_clk);
      `CHK(gates, FWD)
      @(posedge ref_clk);
      {overcurrent_lo_cmp, overcurrent_hi_cmp} <= 2'h3;
      tick(2);
      {overcurrent_lo_cmp, overcurrent_hi_cmp} <= 2'h0;
      wait_st(5'h00, 4);
      `CHK(fault_oe, 1'b1)
      n = 0;
      while (fault_n_out === 1'b0 && n < 200) begin
        @(negedge ref_clk);
        n++;
      end
      `CHK(n >= OCR - 6 && n <= OCR + 4, 1'b1)
      wait_st({FWD, 1'b1}, 8);
    end
    $display("overcurrent test done");
    // Overtemperature, then overvoltage
    for (i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      if (i) supply_overvoltage_level <= 1'b1;
      else thermal_shutdown_level <= 1'b1;
      wait_st(5'h00, 4);
      `CHK(fault_oe, 1'b1)
      tick(10);
      {thermal_shutdown_level, supply_overvoltage_level} <= 2'h0;
      wait_st({FWD, 1'b1}, 6);
    end
    $display("thermal and overvoltage test done");
    // Supply loss mid-run resets the logic
    @(posedge ref_clk);
    rstn <= 1'b0;
    @(negedge ref_clk);
    `CHK({gates, charge_pump_en, fault_n_out, fault_oe}, 7'h02)
    @(posedge ref_clk);
    rstn <= 1'b1;
    wake;
    complete_run;
  end
endmodule // test_hbm_bridge_ctrl
